/* File: core/rss_regs.svh */
// Purpose: constants for the reset and start-up sequencer
// Assumes: 100 MHz system clock, byte addresses on the register bus
// Notes: timing figures kept in their own units, counts derived in the core
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
`define RSS_OFF_CAUSE    8'h00
`define RSS_OFF_STATE    8'h04
`define RSS_OFF_KEEP     8'h08
`define RSS_OFF_WORK     8'h0C
`define RSS_BIT_TO       0
`define RSS_BIT_PD       1
`define RSS_OSC_RC       2'h3
`define RSS_OSC_HS       2'h2
`define RSS_OSC_XT       2'h1
`define RSS_OSC_LP       2'h0
`define RSS_CLK_MHZ      100
`define RSS_SAG_QUAL_US  100
`define RSS_POWERUP_DELAY_TIMER_MS      72
`define RSS_RC_KHZ       32
`define RSS_OST_CYCLES   1024
`define RSS_PIN_FILT     10
`endif

/* File: core/rss_pkg.sv */
// Purpose: types of the reset and start-up sequencer
// Assumes: nothing
// Notes: all core state except the two reset synchroniser flops lives in rss_state_s
package rss_pkg;
  typedef enum logic [2:0] {SQ_START, SQ_POWERUP_DELAY_TIMER, SQ_SAG_HOLD, SQ_OST, SQ_RUN} rss_seq_e;
  typedef enum logic [2:0] {CAUSE_POR, CAUSE_PIN_RUN, CAUSE_PIN_SLEEP, CAUSE_WDT_RESET,
                            CAUSE_WDT_WAKE, CAUSE_SAG, CAUSE_IRQ_WAKE} rss_cause_e;
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } rss_avm_req_s;
  typedef struct packed {
    logic [1:0] osc_mode_sel;
    logic       sag_reset_enable;
    logic       powerup_delay_enable_n;
  } rss_cfg_s;
  typedef struct packed {
    logic        rise_s1;
    logic        rise_s2;
    logic        rise_d;
    logic        low_s1;
    logic        low_s2;
    logic        rc_d;
    logic        osc_d;
    logic [3:0]  pin_cnt;
    logic        pin_low;
    logic [15:0] qual_cnt;
    rss_seq_e    seq;
    logic        sag_seq;
    logic [15:0] powerup_delay_timer_cnt;
    logic [10:0] ost_cnt;
    logic        to_flag;
    logic        pd_flag;
    rss_cause_e  cause;
    logic        wdt_rst;
    logic        wake;
    logic        core_hold;
    logic        full_rst;
    logic [31:0] keep;
    logic [31:0] work;
    logic        ack;
    logic [31:0] rdata;
  } rss_state_s;
endpackage

/* File: core/rss_sequencer.sv */
// Purpose: reset cause tracking and start-up time-out sequencing
// Assumes: rc_clk_in, osc_input_pin_in, pin and watchdog inputs synchronous to clk_in
// Notes: slow clocks are edge-sampled, so they must stay well below clk_in
`timescale 1ns/1ps
`include "rss_regs.svh"

module rss_sequencer
  import rss_pkg::*;
#(
  parameter logic [15:0] SAG_QUAL_CYCLES = 16'(`RSS_SAG_QUAL_US * `RSS_CLK_MHZ),
  parameter logic [15:0] POWERUP_DELAY_TIMER_TICKS      = 16'(`RSS_POWERUP_DELAY_TIMER_MS * `RSS_RC_KHZ),
  parameter logic [10:0] OST_CYCLES      = 11'(`RSS_OST_CYCLES),
  parameter logic [3:0]  PIN_FILT        = 4'(`RSS_PIN_FILT)
) (
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  input  wire rss_avm_req_s  avm_in,
  output logic [31:0]        avm_readdata_out,
  output logic               avm_waitrequest_out,
  input  wire rss_cfg_s      cfg_in,
  input  wire logic          supply_rise_in,
  input  wire logic          supply_low_in,
  input  wire logic          ext_reset_pin_n_in,
  input  wire logic          watchdog_timeout_in,
  input  wire logic          core_asleep_in,
  input  wire logic          irq_wake_in,
  input  wire logic          rc_clk_in,
  input  wire logic          osc_input_pin_in,
  output logic               core_reset_out,
  output logic               reg_reset_out,
  output logic               wake_resume_out,
  output logic               timeout_cause_flag_out,
  output logic               powerdown_cause_flag_out
);

  logic       rst_s1_reg;
  logic       rst_n_reg;
  rss_state_s r_reg;
  rss_state_s r_next;
  logic       por_ev;
  logic       sag_low;
  logic       sag_ev;
  logic       rc_tick;
  logic       osc_tick;
  logic       pin_fall;
  logic       crystal;
  logic       powerup_delay_timer_apply;
  logic       bus_req;
  logic       bus_take;
  logic       bus_do_wr;

  // Decode shared by read and write paths; bit 2 flags a hit
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] s;
    s = 3'h0;
    case (addr)
      `RSS_OFF_CAUSE: s = 3'h4;
      `RSS_OFF_STATE: s = 3'h5;
      `RSS_OFF_KEEP:  s = 3'h6;
      `RSS_OFF_WORK:  s = 3'h7;
      default:        s = 3'h0;
    endcase
    return s;
  endfunction

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  assign por_ev     = r_reg.rise_s2 & ~r_reg.rise_d;
  assign sag_low    = cfg_in.sag_reset_enable & r_reg.low_s2;
  assign sag_ev     = sag_low && (r_reg.qual_cnt == SAG_QUAL_CYCLES - 16'h1);
  assign rc_tick    = rc_clk_in & ~r_reg.rc_d;
  assign osc_tick   = osc_input_pin_in & ~r_reg.osc_d;
  assign pin_fall   = !ext_reset_pin_n_in && (r_reg.pin_cnt == PIN_FILT - 4'h1)
                      && !r_reg.pin_low;
  assign crystal    = (cfg_in.osc_mode_sel != `RSS_OSC_RC);
  // Sag reset forces the delay on regardless of the enable bit
  assign powerup_delay_timer_apply = ~cfg_in.powerup_delay_enable_n | cfg_in.sag_reset_enable;
  assign bus_req    = avm_in.read | avm_in.write;
  assign bus_take   = bus_req & ~r_reg.ack;
  assign bus_do_wr  = avm_in.write & r_reg.ack;

  always_comb begin
    r_next = r_reg;
    // Two-stage synchronisers; first stage feeds only the second
    r_next.rise_s1 = supply_rise_in;
    r_next.rise_s2 = r_reg.rise_s1;
    r_next.rise_d  = r_reg.rise_s2;
    r_next.low_s1  = supply_low_in;
    r_next.low_s2  = r_reg.low_s1;
    r_next.rc_d    = rc_clk_in;
    r_next.osc_d   = osc_input_pin_in;
    r_next.wdt_rst = 1'b0;
    r_next.wake    = 1'b0;

    // Glitch filter: only a low held for PIN_FILT samples counts
    if (ext_reset_pin_n_in) begin
      r_next.pin_cnt = 4'h0;
      r_next.pin_low = 1'b0;
    end else begin
      if (r_reg.pin_cnt != PIN_FILT) begin
        r_next.pin_cnt = r_reg.pin_cnt + 4'h1;
      end
      if (pin_fall) begin
        r_next.pin_low = 1'b1;
      end
    end

    // Qualify time; the count saturates so a long sag fires once
    if (!sag_low) begin
      r_next.qual_cnt = 16'h0;
    end else if (r_reg.qual_cnt != SAG_QUAL_CYCLES) begin
      r_next.qual_cnt = r_reg.qual_cnt + 16'h1;
    end

    case (r_reg.seq)
      SQ_START: begin
        r_next.powerup_delay_timer_cnt = 16'h0;
        r_next.ost_cnt  = 11'h0;
        if (powerup_delay_timer_apply) begin
          r_next.seq = SQ_POWERUP_DELAY_TIMER;
        end else if (crystal) begin
          r_next.seq = SQ_OST;
        end else begin
          r_next.seq = SQ_RUN;
        end
      end
      SQ_POWERUP_DELAY_TIMER: begin
        if (sag_low) begin
          r_next.seq = SQ_SAG_HOLD;
        end else if (rc_tick) begin
          if (r_reg.powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_TICKS - 16'h1) begin
            r_next.ost_cnt = 11'h0;
            r_next.seq     = crystal ? SQ_OST : SQ_RUN;
          end else begin
            r_next.powerup_delay_timer_cnt = r_reg.powerup_delay_timer_cnt + 16'h1;
          end
        end
      end
      SQ_SAG_HOLD: begin
        r_next.powerup_delay_timer_cnt = 16'h0;
        if (!sag_low) begin
          r_next.seq = SQ_POWERUP_DELAY_TIMER;
        end
      end
      SQ_OST: begin
        if (osc_tick) begin
          if (r_reg.ost_cnt == OST_CYCLES - 11'h1) begin
            r_next.seq = SQ_RUN;
          end else begin
            r_next.ost_cnt = r_reg.ost_cnt + 11'h1;
          end
        end
      end
      SQ_RUN: begin
        r_next.sag_seq = 1'b0;
      end
      default: begin
        r_next.seq = SQ_START;
      end
    endcase

    // Hardware causes beat a software write to the flags in the same cycle
    if (por_ev) begin
      r_next.seq     = SQ_START;
      r_next.sag_seq = 1'b1;
      r_next.to_flag = 1'b1;
      r_next.pd_flag = 1'b1;
      r_next.cause   = CAUSE_POR;
    end else if (sag_ev) begin
      r_next.seq     = SQ_SAG_HOLD;
      r_next.sag_seq = 1'b1;
      r_next.to_flag = 1'b1;
      r_next.pd_flag = 1'b1;
      r_next.cause   = CAUSE_SAG;
    end else if (pin_fall) begin
      // Timers keep running under the pin so a long low skips them
      if (core_asleep_in) begin
        r_next.to_flag = 1'b1;
        r_next.pd_flag = 1'b0;
        r_next.cause   = CAUSE_PIN_SLEEP;
      end else begin
        r_next.cause   = CAUSE_PIN_RUN;
      end
    end else if (watchdog_timeout_in && r_reg.seq == SQ_RUN && !r_reg.full_rst) begin
      r_next.to_flag = 1'b0;
      if (core_asleep_in) begin
        r_next.pd_flag = 1'b0;
        r_next.cause   = CAUSE_WDT_WAKE;
        r_next.wake    = 1'b1;
        r_next.ost_cnt = 11'h0;
        r_next.seq     = crystal ? SQ_OST : SQ_RUN;
      end else begin
        r_next.pd_flag = 1'b1;
        r_next.cause   = CAUSE_WDT_RESET;
        r_next.wdt_rst = 1'b1;
      end
    end else if (irq_wake_in && core_asleep_in && r_reg.seq == SQ_RUN && !r_reg.full_rst) begin
      r_next.to_flag = 1'b1;
      r_next.pd_flag = 1'b0;
      r_next.cause   = CAUSE_IRQ_WAKE;
      r_next.wake    = 1'b1;
      r_next.ost_cnt = 11'h0;
      r_next.seq     = crystal ? SQ_OST : SQ_RUN;
    end else if (bus_do_wr && reg_sel(avm_in.address) == 3'h4) begin
      r_next.to_flag = avm_in.writedata[`RSS_BIT_TO];
      r_next.pd_flag = avm_in.writedata[`RSS_BIT_PD];
    end

    // Watchdog reset is purely internal; no pin drive exists here
    r_next.core_hold = (r_next.seq != SQ_RUN) | r_next.pin_low | r_next.wdt_rst;
    r_next.full_rst  = r_next.sag_seq | r_next.pin_low | r_next.wdt_rst;

    if (bus_do_wr && reg_sel(avm_in.address) == 3'h6) begin
      r_next.keep = avm_in.writedata;
    end
    if (r_reg.full_rst) begin
      r_next.work = 32'h0;
    end else if (bus_do_wr && reg_sel(avm_in.address) == 3'h7) begin
      r_next.work = avm_in.writedata;
    end

    // One wait state: data latched on the first cycle, handed out on the second
    r_next.ack = bus_take;
    if (bus_take && avm_in.read) begin
      case (reg_sel(avm_in.address))
        3'h4: r_next.rdata = {25'h0, 3'(r_reg.cause), 2'h0,
                              r_reg.pd_flag, r_reg.to_flag};
        3'h5: r_next.rdata = {5'h0, r_reg.ost_cnt, 8'h0, r_reg.pin_low,
                              r_reg.full_rst, r_reg.core_hold, 2'h0, 3'(r_reg.seq)};
        3'h6: r_next.rdata = r_reg.keep;
        3'h7: r_next.rdata = r_reg.work;
        default: r_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      r_reg           <= '0;
      r_reg.seq       <= SQ_START;
      r_reg.sag_seq   <= 1'b1;
      r_reg.to_flag   <= 1'b1;
      r_reg.pd_flag   <= 1'b1;
      r_reg.cause     <= CAUSE_POR;
      r_reg.core_hold <= 1'b1;
      r_reg.full_rst  <= 1'b1;
      r_reg.rise_s1   <= 1'b1;
      r_reg.rise_s2   <= 1'b1;
      r_reg.rise_d    <= 1'b1;
      r_reg.pin_cnt   <= 4'h0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avm_readdata_out         = r_reg.rdata;
  assign avm_waitrequest_out      = bus_take;
  assign core_reset_out           = r_reg.core_hold;
  assign reg_reset_out            = r_reg.full_rst;
  assign wake_resume_out          = r_reg.wake;
  assign timeout_cause_flag_out   = r_reg.to_flag;
  assign powerdown_cause_flag_out = r_reg.pd_flag;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_reg);

  sequence s_ost_last;
    r_reg.seq == SQ_OST && osc_tick && r_reg.ost_cnt == OST_CYCLES - 11'h1;
  endsequence

  sequence s_quiet;
    !por_ev && !sag_ev && !pin_fall;
  endsequence

  AST_POR_FLAGS: assert property (por_ev |=> r_reg.to_flag && r_reg.pd_flag
    && r_reg.cause == CAUSE_POR && r_reg.seq == SQ_START)
    else $error("power-on did not set both flags");
  AST_WDT_RESET: assert property ($rose(r_reg.wdt_rst) |-> !r_reg.to_flag
    && r_reg.pd_flag && core_reset_out ##1 !r_reg.wdt_rst)
    else $error("watchdog reset flags wrong");
  AST_WAKE_KEEPS: assert property (r_reg.wake |-> !reg_reset_out
    && r_reg.cause != CAUSE_WDT_RESET)
    else $error("wake-up forced a register reset");
  AST_PIN_FILTER: assert property ($rose(r_reg.pin_low) |->
    $past(!ext_reset_pin_n_in, 1) && $past(!ext_reset_pin_n_in, 2)
    && $past(!ext_reset_pin_n_in, 3))
    else $error("short pin pulse reached the reset");
  AST_POWERUP_DELAY_TIMER_HOLD: assert property (r_reg.seq == SQ_POWERUP_DELAY_TIMER |-> core_reset_out)
    else $error("core released during power-up delay");
  AST_RC_NO_OST: assert property ((s_quiet and (r_reg.seq == SQ_START
    && cfg_in.osc_mode_sel == `RSS_OSC_RC && !powerup_delay_timer_apply)) |=> r_reg.seq == SQ_RUN)
    else $error("rc mode with no delay did not start at once");
  AST_SAG_ABANDON: assert property ((s_quiet and (r_reg.seq == SQ_POWERUP_DELAY_TIMER && sag_low))
    |=> r_reg.seq == SQ_SAG_HOLD && r_reg.powerup_delay_timer_cnt == $past(r_reg.powerup_delay_timer_cnt))
    else $error("supply-low during delay not restarted");
  AST_SAG_IGNORED: assert property (!cfg_in.sag_reset_enable |=> r_reg.qual_cnt == 16'h0)
    else $error("supply-low counted while disabled");
  AST_POWERUP_DELAY_TIMER_FORCED: assert property ((s_quiet and (r_reg.seq == SQ_START
    && cfg_in.sag_reset_enable)) |=> r_reg.seq == SQ_POWERUP_DELAY_TIMER)
    else $error("sag enable did not force the delay");
  AST_OST_DONE: assert property ((s_ost_last and s_quiet) |=> r_reg.seq == SQ_RUN
    ##1 (!core_reset_out || pin_fall || r_reg.pin_low || sag_ev || por_ev))
    else $error("settle count did not end at 1024");
  AST_PIN_RELEASE: assert property (r_reg.seq == SQ_RUN && r_reg.pin_low
    && ext_reset_pin_n_in && !por_ev && !sag_ev |=> !core_reset_out)
    else $error("pin release did not start execution");

endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench for the reset and start-up sequencer
// Assumes: short counts: qualify 8, delay 4 ticks, settle 4 edges
// Notes: rc clock 16 cycles a period, oscillator 4, both from one divider
`timescale 1ns/1ps

module tb
  import rss_pkg::*;
;
  logic         clk_in;
  logic         reset_n_in;
  rss_avm_req_s avm;
  rss_cfg_s     cfg;
  logic         rise;
  logic         low;
  logic         pin_n;
  logic         wdt;
  logic         asleep;
  logic         irq;
  logic [7:0]   div;
  logic [31:0]  rdata;
  logic [31:0]  rd;
  logic         wreq;
  logic         core_rst;
  logic         reg_rst;
  logic         wake;
  logic         to_flag;
  logic         pd_flag;
  int           n_errors;
  int           comparisons;

  rss_sequencer #(
    .SAG_QUAL_CYCLES (16'h0008),
    .POWERUP_DELAY_TIMER_TICKS      (16'h0004),
    .OST_CYCLES      (11'h004),
    .PIN_FILT        (4'hA)
  ) rss_sequencer_inst (
    .clk_in                   (clk_in),
    .reset_n_in               (reset_n_in),
    .avm_in                   (avm),
    .avm_readdata_out         (rdata),
    .avm_waitrequest_out      (wreq),
    .cfg_in                   (cfg),
    .supply_rise_in           (rise),
    .supply_low_in            (low),
    .ext_reset_pin_n_in       (pin_n),
    .watchdog_timeout_in      (wdt),
    .core_asleep_in           (asleep),
    .irq_wake_in              (irq),
    .rc_clk_in                (div[3]),
    .osc_input_pin_in         (div[1]),
    .core_reset_out           (core_rst),
    .reg_reset_out            (reg_rst),
    .wake_resume_out          (wake),
    .timeout_cause_flag_out   (to_flag),
    .powerdown_cause_flag_out (pd_flag)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    div <= div + 8'h01;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stall();
    n_errors++;
    report_and_stop();
  endtask

  function automatic logic [31:0] flags();
    return {30'h0, pd_flag, to_flag};
  endfunction

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    int k;
    @(posedge clk_in);
    avm <= '{a, !wr, wr, wd};
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (wreq === 1'b0) break;
    end
    if (k == 50) stall();
    r = rdata;
    avm <= '0;
  endtask

  task automatic hold(output int n);
    for (n = 0; n < 3000; n++) begin
      @(negedge clk_in);
      if (core_rst === 1'b0) break;
    end
    if (n == 3000) stall();
  endtask

  task automatic cause_is(input logic [2:0] e);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk(32'(rd[6:4]), 32'(e));
  endtask

  task automatic t_power_up();
    rss_cfg_s c[5] = '{'{2'h3, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b1}, '{2'h1, 1'b0, 1'b1},
                       '{2'h0, 1'b1, 1'b1}, '{2'h2, 1'b0, 1'b0}};
    int lo[5] = '{40, 0, 10, 58, 58};
    int hi[5] = '{76, 10, 26, 110, 110};
    int n;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      cfg <= c[i];
      repeat (16) @(posedge clk_in);
      reset_n_in <= 1'b1;
      hold(n);
      chk(32'(n >= lo[i] && n <= hi[i]), 32'h1);
      chk(flags(), 32'h3);
    end
  endtask

  task automatic t_regs();
    bus(1'b1, 8'h08, 32'hA5A50001, rd);
    bus(1'b1, 8'h0C, 32'h0000C3C3, rd);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'hA5A50001);
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0000C3C3);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    cause_is(3'h0);
    bus(1'b1, 8'h00, 32'h0, rd);
    // Write lands on the completing edge; look once it has settled
    @(negedge clk_in);
    chk(flags(), 32'h0);
  endtask

  task automatic t_wdt_run();
    bus(1'b1, 8'h0C, 32'h00001234, rd);
    @(posedge clk_in);
    wdt <= 1'b1;
    @(posedge clk_in);
    wdt <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(flags(), 32'h2);
    chk(core_rst, 32'h0);
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'hA5A50001);
    cause_is(3'h3);
  endtask

  task automatic t_wake(input logic by_irq);
    int n;
    int k;
    bus(1'b1, 8'h0C, 32'h00000055, rd);
    @(posedge clk_in);
    asleep <= 1'b1;
    @(posedge clk_in);
    wdt <= !by_irq;
    irq <= by_irq;
    @(posedge clk_in);
    wdt <= 1'b0;
    irq <= 1'b0;
    for (k = 0; k < 20; k++) begin
      @(negedge clk_in);
      if (wake === 1'b1) break;
    end
    if (k == 20) stall();
    @(negedge clk_in);
    chk(wake, 32'h0);
    hold(n);
    chk(32'(n >= 10), 32'h1);
    chk(flags(), by_irq ? 32'h1 : 32'h0);
    @(posedge clk_in);
    asleep <= 1'b0;
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h00000055);
    cause_is(by_irq ? 3'h6 : 3'h4);
  endtask

  task automatic t_pin();
    int k;
    @(posedge clk_in);
    pin_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    pin_n <= 1'b1;
    repeat (20) begin
      @(negedge clk_in);
      chk(core_rst, 32'h0);
    end
    bus(1'b1, 8'h00, 32'h2, rd);
    bus(1'b1, 8'h0C, 32'h00000077, rd);
    @(posedge clk_in);
    pin_n <= 1'b0;
    repeat (150) @(posedge clk_in);
    chk(core_rst, 32'h1);
    chk(reg_rst, 32'h1);
    pin_n <= 1'b1;
    for (k = 0; k < 6; k++) begin
      @(negedge clk_in);
      if (core_rst === 1'b0) break;
    end
    chk(32'(k < 6), 32'h1);
    chk(flags(), 32'h2);
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0);
    cause_is(3'h1);
    @(posedge clk_in);
    asleep <= 1'b1;
    pin_n <= 1'b0;
    repeat (20) @(posedge clk_in);
    pin_n <= 1'b1;
    asleep <= 1'b0;
    hold(k);
    chk(flags(), 32'h1);
    cause_is(3'h2);
  endtask

  task automatic t_sag();
    int n;
    @(posedge clk_in);
    cfg.sag_reset_enable <= 1'b1;
    low <= 1'b1;
    repeat (3) @(posedge clk_in);
    low <= 1'b0;
    repeat (20) begin
      @(negedge clk_in);
      chk(core_rst, 32'h0);
    end
    @(posedge clk_in);
    low <= 1'b1;
    repeat (30) @(posedge clk_in);
    bus(1'b0, 8'h04, 32'h0, rd);
    chk(32'(rd[2:0]), 32'h2);
    chk(core_rst, 32'h1);
    low <= 1'b0;
    repeat (20) @(posedge clk_in);
    chk(core_rst, 32'h1);
    low <= 1'b1;
    repeat (20) @(posedge clk_in);
    bus(1'b0, 8'h04, 32'h0, rd);
    chk(32'(rd[2:0]), 32'h2);
    low <= 1'b0;
    hold(n);
    chk(32'(n >= 48), 32'h1);
    cause_is(3'h5);
    @(posedge clk_in);
    cfg.sag_reset_enable <= 1'b0;
    low <= 1'b1;
    repeat (40) @(posedge clk_in);
    low <= 1'b0;
    chk(core_rst, 32'h0);
  endtask

  task automatic t_rise();
    int n;
    bus(1'b1, 8'h0C, 32'h00000099, rd);
    @(posedge clk_in);
    rise <= 1'b1;
    repeat (8) @(posedge clk_in);
    rise <= 1'b0;
    hold(n);
    chk(32'(n >= 45), 32'h1);
    chk(flags(), 32'h3);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'hA5A50001);
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0);
    cause_is(3'h0);
  endtask

  initial begin
    n_errors = 0;
    comparisons = 0;
    reset_n_in = 1'b0;
    avm = '0;
    cfg = '{2'h2, 1'b0, 1'b0};
    rise = 1'b0;
    low = 1'b0;
    pin_n = 1'b1;
    wdt = 1'b0;
    asleep = 1'b0;
    irq = 1'b0;
    div = 8'h00;
    t_power_up();
    t_regs();
    t_wdt_run();
    t_wake(1'b0);
    t_wake(1'b1);
    t_pin();
    t_sag();
    t_rise();
    report_and_stop();
  end
endmodule
